// ---- ioh_chan.sv ----
// Channel-side model driving the cable into the equipment
module ioh_chan (
    input  wire logic                core_clk_i,
    input  wire ioh_pkg::ioh_chout_t chan_o,
    output ioh_pkg::ioh_chin_t       chan_i
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TMO = 5000;

    initial chan_i = '0;

    // Static levels, held for the whole operation
    task automatic lvl(input logic b, input logic r, input logic w);
        chan_i.chbusy <= b;
        chan_i.rd     <= r;
        chan_i.wr     <= w;
        @(posedge core_clk_i);
    endtask

    // Master clear pulse, long enough to pass the input filter
    task automatic clear();
        chan_i.mclr <= 1'h1;
        repeat (8) @(posedge core_clk_i);
        chan_i.mclr <= 1'h0;
        repeat (8) @(posedge core_clk_i);
    endtask

    // One strobe: k 0 connect, 1 function, 2 data
    task automatic xfer(input int k, input logic [11:0] c, input logic bad,
                        output logic [3:0] a, output logic [11:0] d, output int n);
        logic pe;
        pe = 1'h0;
        n  = 0;
        chan_i.data   <= c;
        chan_i.parity <= ~^c ^ bad;
        @(posedge core_clk_i);
        chan_i.connect <= (k == 0);
        chan_i.func    <= (k == 1);
        chan_i.dsig    <= (k == 2);
        do
        begin
            @(posedge core_clk_i);
            n++;
            pe |= chan_o.par_err;
        end
        while (!(chan_o.reply | chan_o.reject | chan_o.eor) && n < TMO);
        a = {chan_o.reply, chan_o.reject, chan_o.eor, pe};
        d = chan_o.data;
        chan_i.connect <= 1'h0;
        chan_i.func    <= 1'h0;
        chan_i.dsig    <= 1'h0;
        chan_i.data    <= ~c;
        repeat (8) @(posedge core_clk_i);
    endtask
endmodule

// ---- ioh_equip.sv ----
// Equipment-side controller for the 12-bit channel handshake
// Function
// - data lines driven only on read replies
// - matching available equipment replies, else rejects
// - upper three bits pick equipment number
// - non-matching equipment never answers connect
// - reserved equipment rejects, keeps status enabled
// - other selection code disconnects us
// - disconnect fast, answer no sooner than 2us
// - function code answered reply or reject
// - function ignored when not connected
// - bad function parity: no function, parity error
// - pending function locks out further codes
// - identical code rejected unless repeatable
// - channel busy makes ready equipment busy
// - read from record start, stop on drop
// - read restart waits for next record
// - write from record start, close on drop
// - reply per data strobe, drops with strobe
// - end of record answers first strobe after
// - odd parity checked on channel words
//
// Chosen here: the Avalon-MM register port and the placing of the registers.
module ioh_equip (
    input  wire logic               core_clk_i,
    input  wire logic               rst_i,
    input  wire logic [4:0]         avs_address_i,
    input  wire logic               avs_read_i,
    input  wire logic               avs_write_i,
    input  wire logic [31:0]        avs_writedata_i,
    output logic      [31:0]        avs_readdata_o,
    output logic                    avs_waitrequest_o,
    input  wire ioh_pkg::ioh_chin_t chan_i,
    output ioh_pkg::ioh_chout_t     chan_o
);
    ioh_pkg::ioh_chin_t  s1_ff, s2_ff, s3_ff, in_ff;
    ioh_pkg::ioh_chout_t out_ff;
    ioh_pkg::ioh_state_t state_ff;
    ioh_pkg::ioh_ans_t   ans_ff, nxt_ans;
    logic [9:0]  ctrl_ff;
    logic [11:0] fn_code_ff, rdata_ff, wdata_ff;
    logic [8:0]  sel_ff;
    logic [6:0]  cnt_ff, age_ff;
    logic [31:0] rd_mux;
    logic        wait_ff, conn_ff, stat_en_ff, fn_pend_ff, busy_ff;
    logic        rd_act_ff, wr_act_ff, bound_ff, eor_pend_ff;
    logic        rvalid_ff, wnew_ff, parseen_ff, closed_ff, seen_ff;
    logic        bus_wr, bus_rd, wr_ctrl, rec_end_p, op_done_p, fn_done_p;
    logic        idle, all_low, par_ok, match, fn_ok;
    logic        ev_conn, ev_func, ev_rd, ev_wr, go, start_rec, wr_close;

    assign avs_waitrequest_o = wait_ff;
    assign avs_readdata_o    = rd_mux;
    assign chan_o            = out_ff;

    // ==========================================================
    // Pin synchroniser, change taken once stages two and three agree
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
            in_ff <= '0;
        end
        else
        begin
            s1_ff <= chan_i;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            in_ff <= (s2_ff & s3_ff) | (in_ff & (s2_ff | s3_ff));
        end
    end

    // ==========================================================
    // Avalon slave, one wait cycle per access
    assign bus_wr    = avs_write_i && !wait_ff;
    assign bus_rd    = avs_read_i && !wait_ff;
    assign wr_ctrl   = bus_wr && avs_address_i == ioh_pkg::A_CTRL;
    assign rec_end_p = wr_ctrl && avs_writedata_i[ioh_pkg::CT_REC_END];
    assign op_done_p = wr_ctrl && avs_writedata_i[ioh_pkg::CT_OP_DONE];
    assign fn_done_p = wr_ctrl && avs_writedata_i[ioh_pkg::CT_FN_DONE];

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wait_ff <= 1'b1;
            rd_mux  <= 32'h0;
            ctrl_ff <= ioh_pkg::CTRL_RST;
        end
        else
        begin
            wait_ff <= !((avs_read_i || avs_write_i) && wait_ff);
            if (wr_ctrl)
                ctrl_ff <= avs_writedata_i[9:0] & ioh_pkg::CTRL_WMASK;
            if (avs_read_i && wait_ff)
            begin
                case (avs_address_i)
                    ioh_pkg::A_CTRL:   rd_mux <= {22'h0, ctrl_ff};
                    ioh_pkg::A_STATUS: rd_mux <= {24'h0, stat_en_ff, closed_ff, parseen_ff, fn_pend_ff,
                                                  wr_act_ff, rd_act_ff, busy_ff, conn_ff};
                    ioh_pkg::A_FUNC:   rd_mux <= {20'h0, fn_code_ff};
                    ioh_pkg::A_RDATA:  rd_mux <= {19'h0, rvalid_ff, rdata_ff};
                    ioh_pkg::A_WDATA:  rd_mux <= {19'h0, wnew_ff, wdata_ff};
                    ioh_pkg::A_SEL:    rd_mux <= {23'h0, sel_ff};
                    default:           rd_mux <= 32'h0;
                endcase
            end
        end
    end

    // ==========================================================
    // Strobe decode
    assign idle    = state_ff == ioh_pkg::S_IDLE;
    assign all_low = !(in_ff.connect || in_ff.func || in_ff.dsig);
    assign par_ok  = ^{in_ff.data, in_ff.parity};
    assign match   = in_ff.data[11:9] == ctrl_ff[ioh_pkg::CT_EQN_LSB +: 3];
    assign fn_ok   = !fn_pend_ff || (in_ff.data == fn_code_ff && ctrl_ff[ioh_pkg::CT_REPEAT]);
    assign ev_conn = idle && !in_ff.mclr && !seen_ff && in_ff.connect;
    assign ev_func = idle && !in_ff.mclr && !seen_ff && in_ff.func && conn_ff;
    assign ev_wr   = idle && !in_ff.mclr && !seen_ff && in_ff.dsig && conn_ff && wr_act_ff && in_ff.wr;
    assign ev_rd   = idle && !in_ff.mclr && !seen_ff && in_ff.dsig && conn_ff && rd_act_ff
                     && (eor_pend_ff || rvalid_ff);
    assign go      = (ev_conn && par_ok && match) || (ev_func && par_ok) || ev_wr || ev_rd;

    always_comb
    begin
        nxt_ans = ioh_pkg::ANS_NONE;
        if (ev_conn)
            nxt_ans = ctrl_ff[ioh_pkg::CT_AVAIL] ? ioh_pkg::ANS_REPLY : ioh_pkg::ANS_REJECT;
        else if (ev_func)
            nxt_ans = fn_ok ? ioh_pkg::ANS_REPLY : ioh_pkg::ANS_REJECT;
        else if (ev_rd && eor_pend_ff)
            nxt_ans = ioh_pkg::ANS_EOR;
        else if (ev_rd || ev_wr)
            nxt_ans = ioh_pkg::ANS_REPLY;
    end

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
            seen_ff <= 1'b0;
        else if (all_low)
            seen_ff <= 1'b0;
        else if (ev_conn || ev_func || ev_wr || ev_rd)
            seen_ff <= 1'b1;
    end

    // ==========================================================
    // Answer sequencer
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_ff <= ioh_pkg::S_IDLE;
            cnt_ff   <= 7'h0;
            ans_ff   <= ioh_pkg::ANS_NONE;
        end
        else if (in_ff.mclr)
            state_ff <= ioh_pkg::S_IDLE;
        else
        begin
            case (state_ff)
                ioh_pkg::S_IDLE:
                    if (go)
                    begin
                        state_ff <= ioh_pkg::S_DELAY;
                        cnt_ff   <= ev_conn ? ioh_pkg::ANS_MIN_CNT : 7'h0;
                        ans_ff   <= nxt_ans;
                    end
                ioh_pkg::S_DELAY:
                    if (all_low)
                        state_ff <= ioh_pkg::S_IDLE;
                    else if (cnt_ff == 7'h0)
                        state_ff <= ioh_pkg::S_HOLD;
                    else
                        cnt_ff <= cnt_ff - 7'h1;
                ioh_pkg::S_HOLD:
                    if (all_low)
                        state_ff <= ioh_pkg::S_IDLE;
                default:
                    state_ff <= ioh_pkg::S_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Channel-facing outputs
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
            out_ff <= '0;
        else if (in_ff.mclr)
            out_ff <= '0;
        else
        begin
            out_ff.stat_oe                   <= stat_en_ff;
            out_ff.status                    <= 12'h0;
            out_ff.status[ioh_pkg::SL_READY] <= ctrl_ff[ioh_pkg::CT_READY];
            out_ff.status[ioh_pkg::SL_BUSY]  <= busy_ff;
            out_ff.status[ioh_pkg::SL_ERROR] <= ctrl_ff[ioh_pkg::CT_ERR];
            if (state_ff == ioh_pkg::S_DELAY && cnt_ff == 7'h0 && !all_low)
            begin
                out_ff.reply  <= ans_ff == ioh_pkg::ANS_REPLY;
                out_ff.reject <= ans_ff == ioh_pkg::ANS_REJECT;
                out_ff.eor    <= ans_ff == ioh_pkg::ANS_EOR;
            end
            else if (all_low)
            begin
                out_ff.reply   <= 1'b0;
                out_ff.reject  <= 1'b0;
                out_ff.eor     <= 1'b0;
                out_ff.data_oe <= 1'b0;
                out_ff.par_err <= 1'b0;
            end
            if (ev_rd && !eor_pend_ff)
            begin
                out_ff.data    <= rdata_ff;
                out_ff.data_oe <= 1'b1;
            end
            if ((ev_func || ev_wr) && !par_ok)
                out_ff.par_err <= 1'b1;
        end
    end

    // ==========================================================
    // Selection and function state
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            conn_ff    <= 1'b0;
            stat_en_ff <= 1'b0;
            sel_ff     <= 9'h0;
        end
        else if (in_ff.mclr)
        begin
            conn_ff    <= 1'b0;
            stat_en_ff <= 1'b0;
        end
        else if (ev_conn)
        begin
            conn_ff    <= par_ok && match && ctrl_ff[ioh_pkg::CT_AVAIL];
            stat_en_ff <= par_ok && match;
            if (par_ok && match)
                sel_ff <= in_ff.data[8:0];
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            fn_pend_ff <= 1'b0;
            fn_code_ff <= 12'h0;
        end
        else if (in_ff.mclr)
            fn_pend_ff <= 1'b0;
        else if (ev_func && par_ok && fn_ok)
        begin
            fn_pend_ff <= 1'b1;
            fn_code_ff <= in_ff.data;
        end
        else if (fn_done_p)
            fn_pend_ff <= 1'b0;
    end

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
            busy_ff <= 1'b0;
        else if (in_ff.mclr || !ctrl_ff[ioh_pkg::CT_READY])
            busy_ff <= 1'b0;
        else if (in_ff.chbusy && conn_ff)
            busy_ff <= 1'b1;
        else if (op_done_p)
            busy_ff <= 1'b0;
    end

    // ==========================================================
    // Record tracking for read and write
    assign start_rec = bound_ff && conn_ff && (in_ff.rd || in_ff.wr);
    assign wr_close  = wr_act_ff && !in_ff.wr;

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            bound_ff    <= 1'b1;
            rd_act_ff   <= 1'b0;
            wr_act_ff   <= 1'b0;
            eor_pend_ff <= 1'b0;
        end
        else if (in_ff.mclr)
        begin
            bound_ff    <= 1'b1;
            rd_act_ff   <= 1'b0;
            wr_act_ff   <= 1'b0;
            eor_pend_ff <= 1'b0;
        end
        else
        begin
            if (rec_end_p || wr_close)
                bound_ff <= 1'b1;
            else if (start_rec)
                bound_ff <= 1'b0;
            if (!in_ff.rd || !conn_ff)
                rd_act_ff <= 1'b0;
            else if (start_rec)
                rd_act_ff <= 1'b1;
            if (!in_ff.wr || !conn_ff)
                wr_act_ff <= 1'b0;
            else if (start_rec)
                wr_act_ff <= 1'b1;
            if (rec_end_p && rd_act_ff && in_ff.rd)
                eor_pend_ff <= 1'b1;
            else if ((ev_rd && eor_pend_ff) || !in_ff.rd)
                eor_pend_ff <= 1'b0;
        end
    end

    // ==========================================================
    // Data words and sticky flags, set wins over clear
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rdata_ff   <= 12'h0;
            rvalid_ff  <= 1'b0;
            wdata_ff   <= 12'h0;
            wnew_ff    <= 1'b0;
            parseen_ff <= 1'b0;
            closed_ff  <= 1'b0;
        end
        else
        begin
            if (bus_wr && avs_address_i == ioh_pkg::A_RDATA)
            begin
                rdata_ff  <= avs_writedata_i[11:0];
                rvalid_ff <= 1'b1;
            end
            else if (ev_rd && !eor_pend_ff)
                rvalid_ff <= 1'b0;
            if (ev_wr)
            begin
                wdata_ff <= in_ff.data;
                wnew_ff  <= 1'b1;
            end
            else if (bus_rd && avs_address_i == ioh_pkg::A_WDATA)
                wnew_ff <= 1'b0;
            if ((ev_conn || ev_func || ev_wr) && !par_ok)
                parseen_ff <= 1'b1;
            else if (bus_rd && avs_address_i == ioh_pkg::A_STATUS)
                parseen_ff <= 1'b0;
            if (wr_close)
                closed_ff <= 1'b1;
            else if (bus_rd && avs_address_i == ioh_pkg::A_STATUS)
                closed_ff <= 1'b0;
        end
    end

    // ==========================================================
    // Checks
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
            age_ff <= 7'h0;
        else if (!in_ff.connect)
            age_ff <= 7'h0;
        else if (age_ff != 7'h7F)
            age_ff <= age_ff + 7'h1;
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    property p_ans_late;
        $rose(out_ff.reply || out_ff.reject) && in_ff.connect |-> age_ff > ioh_pkg::ANS_MIN_CNT;
    endproperty
    a_ans_late: assert property (p_ans_late) else $error("Selection answered too early");

    property p_disc;
        ev_conn && par_ok && !match |=> !conn_ff && !stat_en_ff;
    endproperty
    a_disc: assert property (p_disc) else $error("No disconnect on foreign code");

    property p_quiet;
        ev_conn && !match |=> (!out_ff.reply && !out_ff.reject)[*8];
    endproperty
    a_quiet: assert property (p_quiet) else $error("Answered foreign selection");

    property p_fn_par;
        ev_func && !par_ok |=> out_ff.par_err && fn_code_ff == $past(fn_code_ff) && state_ff == ioh_pkg::S_IDLE;
    endproperty
    a_fn_par: assert property (p_fn_par) else $error("Bad function parity mishandled");

    property p_fn_lock;
        ev_func && par_ok && fn_pend_ff && !fn_ok |-> ##2 out_ff.reject && !out_ff.reply;
    endproperty
    a_fn_lock: assert property (p_fn_lock) else $error("Locked function not rejected");

    property p_reply_drop;
        out_ff.reply && all_low && !in_ff.mclr |=> !out_ff.reply && !out_ff.data_oe;
    endproperty
    a_reply_drop: assert property (p_reply_drop) else $error("Reply held after strobe");

    property p_eor;
        ev_rd && eor_pend_ff |-> ##2 out_ff.eor && !out_ff.reply;
    endproperty
    a_eor: assert property (p_eor) else $error("End of record not given");

    property p_rd_withhold;
        $rose(in_ff.rd) && !bound_ff |=> !rd_act_ff;
    endproperty
    a_rd_withhold: assert property (p_rd_withhold) else $error("Read resumed mid record");

    property p_busy;
        in_ff.chbusy && conn_ff && ctrl_ff[ioh_pkg::CT_READY] && !in_ff.mclr |=> busy_ff;
    endproperty
    a_busy: assert property (p_busy) else $error("Busy not raised");

    property p_wr_close;
        wr_close && !in_ff.mclr |=> bound_ff && closed_ff && !wr_act_ff;
    endproperty
    a_wr_close: assert property (p_wr_close) else $error("Record not closed");

    property p_wr_par;
        ev_wr && !par_ok |=> out_ff.par_err ##1 out_ff.reply;
    endproperty
    a_wr_par: assert property (p_wr_par) else $error("Write parity error mishandled");

    c_conn_reply: cover property (ev_conn && match ##[1:200] out_ff.reply);
    c_fn_reject: cover property (ev_func ##2 out_ff.reject);
    c_eor: cover property (out_ff.eor);
    c_wr_close: cover property (wr_close);
endmodule

// ---- ioh_equip_tb.sv ----
// Self-checking bench for the equipment-side channel handshake
module ioh_equip_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TMO = 5000;
    logic                core_clk_i      = 1'h0;
    logic                rst_i           = 1'h1;
    logic [4:0]          avs_address_i   = 5'h00;
    logic                avs_read_i      = 1'h0;
    logic                avs_write_i     = 1'h0;
    logic [31:0]         avs_writedata_i = 32'h0;
    logic [31:0]         avs_readdata_o;
    logic                avs_waitrequest_o;
    ioh_pkg::ioh_chin_t  chan_i;
    ioh_pkg::ioh_chout_t chan_o;
    logic [3:0]          ans;
    logic [11:0]         dat;
    logic [31:0]         rv;
    int                  n;
    int                  checks    = 0;
    int                  err_total = 0;
    int                  cyc       = 0;

    always #10 core_clk_i = ~core_clk_i;

    ioh_equip dut (
        .core_clk_i       (core_clk_i),
        .rst_i            (rst_i),
        .avs_address_i    (avs_address_i),
        .avs_read_i       (avs_read_i),
        .avs_write_i      (avs_write_i),
        .avs_writedata_i  (avs_writedata_i),
        .avs_readdata_o   (avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o),
        .chan_i           (chan_i),
        .chan_o           (chan_o)
    );

    ioh_chan ch (.core_clk_i(core_clk_i), .chan_o(chan_o), .chan_i(chan_i));

    // ==========================================
    // Helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] v);
        avs_address_i   <= a;
        avs_writedata_i <= v;
        avs_write_i     <= w;
        avs_read_i      <= ~w;
        do
        begin
            @(posedge core_clk_i);
        end
        while (avs_waitrequest_o !== 1'h0);
        rv = avs_readdata_o;
        avs_write_i <= 1'h0;
        avs_read_i  <= 1'h0;
        @(posedge core_clk_i);
    endtask

    task automatic wrap_up();
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
        begin
            $display("*** PASS ***");
        end
        else
        begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ==========================================
    // Scenarios
    task automatic t_select();
        bus(1'h0, ioh_pkg::A_CTRL, 32'h0);
        chk(rv, 32'h0);
        bus(1'h1, ioh_pkg::A_CTRL, 32'h1D);
        bus(1'h0, ioh_pkg::A_CTRL, 32'h0);
        chk(rv, 32'h1D);
        bus(1'h0, 5'h18, 32'h0);
        chk(rv, 32'h0);
        ch.xfer(0, 12'h433, 1'h0, ans, dat, n);
        chk(32'(n), 32'(TMO));
        ch.xfer(0, 12'hA33, 1'h1, ans, dat, n);
        chk(32'(n), 32'(TMO));
        ch.xfer(0, 12'hA33, 1'h0, ans, dat, n);
        chk(32'(ans), 32'h8);
        chk(32'(n >= 100), 32'h1);
        bus(1'h0, ioh_pkg::A_SEL, 32'h0);
        chk(rv, 32'h033);
    endtask

    task automatic t_func();
        ch.xfer(1, 12'h041, 1'h0, ans, dat, n);
        chk(32'(ans), 32'h8);
        ch.xfer(1, 12'h041, 1'h0, ans, dat, n);
        chk(32'(ans), 32'h4);
        ch.xfer(1, 12'h042, 1'h0, ans, dat, n);
        chk(32'(ans), 32'h4);
        bus(1'h0, ioh_pkg::A_FUNC, 32'h0);
        chk(rv, 32'h041);
        bus(1'h1, ioh_pkg::A_CTRL, 32'h11D);
        ch.xfer(1, 12'h041, 1'h0, ans, dat, n);
        chk(32'(ans), 32'h8);
        bus(1'h1, ioh_pkg::A_CTRL, 32'h9D);
        ch.xfer(1, 12'h043, 1'h1, ans, dat, n);
        chk(32'(ans), 32'h1);
    endtask

    task automatic t_read();
        ch.lvl(1'h1, 1'h1, 1'h0);
        repeat (6) @(posedge core_clk_i);
        bus(1'h0, ioh_pkg::A_STATUS, 32'h0);
        chk(rv & 32'h2, 32'h2);
        chk(32'(chan_o.status), 32'h3);
        bus(1'h1, ioh_pkg::A_RDATA, 32'h1ABC);
        ch.xfer(2, 12'h000, 1'h0, ans, dat, n);
        chk(32'(ans), 32'h8);
        chk(32'(dat), 32'hABC);
        chk(32'(chan_o.data_oe), 32'h0);
        bus(1'h1, ioh_pkg::A_CTRL, 32'h3D);
        ch.xfer(2, 12'h000, 1'h0, ans, dat, n);
        chk(32'(ans), 32'h2);
    endtask

    task automatic t_write();
        ch.lvl(1'h1, 1'h0, 1'h0);
        repeat (6) @(posedge core_clk_i);
        bus(1'h1, ioh_pkg::A_CTRL, 32'h3D);
        ch.lvl(1'h1, 1'h0, 1'h1);
        repeat (6) @(posedge core_clk_i);
        ch.xfer(2, 12'h5A5, 1'h0, ans, dat, n);
        chk(32'(ans), 32'h8);
        bus(1'h0, ioh_pkg::A_WDATA, 32'h0);
        chk(rv, 32'h15A5);
        ch.xfer(2, 12'h0F0, 1'h1, ans, dat, n);
        chk(32'(ans), 32'h9);
        ch.lvl(1'h1, 1'h0, 1'h0);
        repeat (6) @(posedge core_clk_i);
        bus(1'h0, ioh_pkg::A_STATUS, 32'h0);
        chk(rv & 32'h40, 32'h40);
    endtask

    task automatic t_drop();
        ch.xfer(0, 12'h233, 1'h0, ans, dat, n);
        bus(1'h0, ioh_pkg::A_STATUS, 32'h0);
        chk(rv & 32'h1, 32'h0);
        chk(32'(chan_o.stat_oe), 32'h0);
        ch.xfer(1, 12'h041, 1'h0, ans, dat, n);
        chk(32'(n), 32'(TMO));
        bus(1'h1, ioh_pkg::A_CTRL, 32'h0D);
        ch.xfer(0, 12'hA33, 1'h0, ans, dat, n);
        chk(32'(ans), 32'h4);
        chk(32'(chan_o.stat_oe), 32'h1);
        bus(1'h0, ioh_pkg::A_STATUS, 32'h0);
        chk(rv & 32'h80, 32'h80);
        ch.clear();
        bus(1'h0, ioh_pkg::A_STATUS, 32'h0);
        chk(rv, 32'h0);
        chk(32'(chan_o.stat_oe), 32'h0);
    endtask

    always @(posedge core_clk_i)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            err_total++;
            wrap_up();
        end
    end

    initial
    begin
        repeat (12) @(posedge core_clk_i);
        rst_i <= 1'h0;
        @(posedge core_clk_i);
        t_select();
        t_func();
        t_read();
        t_write();
        t_drop();
        wrap_up();
    end
endmodule

// ---- ioh_pkg.sv ----
// Constants and carrier types for the channel handshake equipment side
package ioh_pkg;
    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned DISC_MAX_NS   = 1000;
    localparam int unsigned ANS_MIN_NS    = 2000;
    localparam int unsigned DISC_MAX_CYC  = DISC_MAX_NS / CLK_PERIOD_NS;
    localparam int unsigned ANS_MIN_CYC   = (ANS_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [6:0]  ANS_MIN_CNT   = 7'(ANS_MIN_CYC);

    // Register byte offsets
    localparam logic [4:0] A_CTRL   = 5'h00;
    localparam logic [4:0] A_STATUS = 5'h04;
    localparam logic [4:0] A_FUNC   = 5'h08;
    localparam logic [4:0] A_RDATA  = 5'h0C;
    localparam logic [4:0] A_WDATA  = 5'h10;
    localparam logic [4:0] A_SEL    = 5'h14;

    // Control register fields
    localparam int unsigned CT_EQN_LSB = 0;
    localparam int unsigned CT_READY   = 3;
    localparam int unsigned CT_AVAIL   = 4;
    localparam int unsigned CT_REC_END = 5;
    localparam int unsigned CT_OP_DONE = 6;
    localparam int unsigned CT_FN_DONE = 7;
    localparam int unsigned CT_REPEAT  = 8;
    localparam int unsigned CT_ERR     = 9;
    localparam logic [9:0]  CTRL_WMASK = 10'h31F;
    localparam logic [9:0]  CTRL_RST   = 10'h000;

    // Status line bit positions
    localparam int unsigned SL_READY = 0;
    localparam int unsigned SL_BUSY  = 1;
    localparam int unsigned SL_ERROR = 10;

    typedef struct packed {
        logic        mclr;
        logic        connect;
        logic        func;
        logic        dsig;
        logic        chbusy;
        logic        rd;
        logic        wr;
        logic        parity;
        logic [11:0] data;
    } ioh_chin_t;

    typedef struct packed {
        logic        reply;
        logic        reject;
        logic        eor;
        logic        par_err;
        logic        data_oe;
        logic        stat_oe;
        logic [11:0] data;
        logic [11:0] status;
    } ioh_chout_t;

    typedef enum logic [1:0] {
        S_IDLE  = 2'h0,
        S_DELAY = 2'h1,
        S_HOLD  = 2'h3
    } ioh_state_t;

    typedef enum logic [1:0] {
        ANS_NONE   = 2'h0,
        ANS_REPLY  = 2'h1,
        ANS_REJECT = 2'h2,
        ANS_EOR    = 2'h3
    } ioh_ans_t;
endpackage
